/* File: design/ots_sequencer.sv */
// Output transient sequencer: step, pulse and list transients with trigger state machine
`timescale 1ns/1ps
module ots_sequencer
  import ots_pkg::*;
#(
  parameter int NUM_FUNC   = 2,
  parameter int LVL_W      = 16,
  parameter int LIST_DEPTH = 32,
  parameter int TICK_DIV   = TICK_CYC
) (
  // Clock and reset
  input  wire logic                           clk,
  input  wire logic                           sys_rst,
  // Register port
  input  wire logic [ADDR_W-1:0]              reg_addr,
  input  wire logic [DATA_W-1:0]              reg_wdata,
  input  wire logic                           reg_we,
  input  wire logic                           reg_re,
  output logic      [DATA_W-1:0]              reg_rdata,
  // Internal phase reference in degrees
  input  wire logic [PHASE_W-1:0]             phase_ref,
  // Function outputs and status
  output logic      [NUM_FUNC-1:0][LVL_W-1:0] func_level,
  output logic      [2:0]                     seq_state,
  output logic                                save_strobe
);

  localparam int NLIST = NUM_FUNC + 1;  // Function lists then the dwell list
  localparam int DWL   = NUM_FUNC;
  localparam int LEN_W = PTR_IDX_W + 1;
  localparam int TCK_W = $clog2(TICK_DIV + 1);

  // Refuse sizes that the pointer select, index and level fields cannot serve
  if (NUM_FUNC < 1 || NUM_FUNC + 1 > 2 ** PTR_SEL_W || LIST_DEPTH < 1 || LIST_DEPTH > 2 ** PTR_IDX_W
      || LVL_W < 1 || LVL_W > 16 || TICK_DIV < 1) begin : g_bad_param
    $error("ots_sequencer: unsupported parameter values");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state
  ots_cfg_t                         cfg_r;
  logic [PHASE_W-1:0]               sync_ph_r;
  logic [15:0]                      pcount_r;
  logic [15:0]                      pperiod_r;
  logic [6:0]                       pulse_duty_percent_r;
  logic [15:0]                      pwidth_r;
  logic                             width_sel_r;
  logic [15:0]                      lcount_r;
  logic [PTR_SEL_W+PTR_IDX_W-1:0]   lptr_r;
  logic [NLIST-1:0][LIST_DEPTH-1:0][LVL_W-1:0] list_mem_r;
  logic [NLIST-1:0][LEN_W-1:0]      len_r;
  logic [NUM_FUNC-1:0][LVL_W-1:0]   imm_r;
  logic [NUM_FUNC-1:0][LVL_W-1:0]   trg_r;
  logic [NUM_FUNC-1:0][LVL_W-1:0]   out_r;
  ots_state_t                       state_r;
  logic [PTR_IDX_W-1:0]             idx_r;
  logic [15:0]                      rep_r;
  logic [15:0]                      pdone_r;
  logic [15:0]                      tcnt_r;
  logic                             err_r;
  logic                             exec_r;
  logic                             saved_r;
  logic                             sref_r;
  logic                             save_r;
  logic [TCK_W-1:0]                 div_r;
  logic                             tick_r;
  logic [DATA_W-1:0]                rdata_r;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode into write strobes
  logic                  wr_ctrl, wr_cfg, wr_sph, wr_pcnt, wr_pper, wr_pduty, wr_pwid, wr_lcnt, wr_lptr, wr_ldat;
  logic [NUM_FUNC-1:0]   wr_imm, wr_trg;
  logic [NLIST-1:0]      wr_len;

  always_comb begin
    wr_ctrl  = 1'b0;
    wr_cfg   = 1'b0;
    wr_sph   = 1'b0;
    wr_pcnt  = 1'b0;
    wr_pper  = 1'b0;
    wr_pduty = 1'b0;
    wr_pwid  = 1'b0;
    wr_lcnt  = 1'b0;
    wr_lptr  = 1'b0;
    wr_ldat  = 1'b0;
    wr_imm   = '0;
    wr_trg   = '0;
    wr_len   = '0;
    if (reg_we) begin
      if (reg_addr == OFS_CTRL) wr_ctrl = 1'b1;
      else if (reg_addr == OFS_CFG) wr_cfg = 1'b1;
      else if (reg_addr == OFS_SYNC_PH) wr_sph = 1'b1;
      else if (reg_addr == OFS_PCOUNT) wr_pcnt = 1'b1;
      else if (reg_addr == OFS_PPERIOD) wr_pper = 1'b1;
      else if (reg_addr == OFS_PDUTY) wr_pduty = 1'b1;
      else if (reg_addr == OFS_PWIDTH) wr_pwid = 1'b1;
      else if (reg_addr == OFS_LCOUNT) wr_lcnt = 1'b1;
      else if (reg_addr == OFS_LPTR) wr_lptr = 1'b1;
      else if (reg_addr == OFS_LDATA) wr_ldat = 1'b1;
      for (int f = 0; f < NUM_FUNC; f++) begin
        if (reg_addr == OFS_IMM_BASE + ADDR_W'(WORD_BYTES * f)) wr_imm[f] = 1'b1;
        if (reg_addr == OFS_TRG_BASE + ADDR_W'(WORD_BYTES * f)) wr_trg[f] = 1'b1;
      end
      for (int l = 0; l < NLIST; l++) begin
        if (reg_addr == OFS_LEN_BASE + ADDR_W'(WORD_BYTES * l)) wr_len[l] = 1'b1;
      end
    end
  end

  // Commands from the control word
  logic cmd_arm, cmd_abort, cmd_trig, cmd_save, cmd_clr;
  assign cmd_arm   = wr_ctrl & reg_wdata[CTL_ARM];
  assign cmd_abort = wr_ctrl & reg_wdata[CTL_ABORT];
  assign cmd_trig  = wr_ctrl & reg_wdata[CTL_TRIG];
  assign cmd_save  = wr_ctrl & reg_wdata[CTL_SAVE];
  assign cmd_clr   = wr_ctrl & reg_wdata[CTL_CLR];

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cfg_r                <= CFG_RST;
      sync_ph_r            <= '0;
      pcount_r             <= PCOUNT_RST;
      pperiod_r            <= PPERIOD_RST;
      pulse_duty_percent_r <= PDUTY_RST;
      pwidth_r             <= PWIDTH_RST;
      width_sel_r          <= 1'b0;
      lcount_r             <= LCOUNT_RST;
    end else begin
      if (wr_cfg) cfg_r <= ots_cfg_t'(reg_wdata[CFG_W-1:0]);
      if (wr_sph) sync_ph_r <= reg_wdata[PHASE_W-1:0];
      if (wr_pcnt) pcount_r <= reg_wdata[15:0];
      if (wr_pper) pperiod_r <= reg_wdata[15:0];
      if (wr_lcnt) lcount_r <= reg_wdata[15:0];
      // Last written of duty or width owns the high time
      if (wr_pduty) begin
        pulse_duty_percent_r <= reg_wdata[6:0];
        width_sel_r          <= 1'b0;
      end else if (wr_pwid) begin
        pwidth_r    <= reg_wdata[15:0];
        width_sel_r <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // List storage, lengths and load pointer with auto increment
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      lptr_r <= '0;
      len_r  <= '{default: LEN_W'(1)};
    end else begin
      if (wr_lptr) lptr_r <= reg_wdata[PTR_SEL_W+PTR_IDX_W-1:0];
      else if (wr_ldat) lptr_r[PTR_IDX_W-1:0] <= lptr_r[PTR_IDX_W-1:0] + 1'b1;
      for (int l = 0; l < NLIST; l++) begin
        if (wr_len[l] && reg_wdata[LEN_W-1:0] <= LEN_W'(LIST_DEPTH)) len_r[l] <= reg_wdata[LEN_W-1:0];
      end
    end
  end

  // Entries are plain storage without reset
  always_ff @(posedge clk) begin
    if (wr_ldat && 32'(lptr_r[PTR_SEL_LSB+:PTR_SEL_W]) < NLIST && 32'(lptr_r[PTR_IDX_W-1:0]) < LIST_DEPTH)
      list_mem_r[lptr_r[PTR_SEL_LSB+:PTR_SEL_W]][lptr_r[PTR_IDX_W-1:0]] <= reg_wdata[LVL_W-1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // List length check: every list holds one entry or the common count
  logic [LEN_W-1:0] npts;
  logic             len_bad;

  always_comb begin
    npts    = '0;
    len_bad = 1'b0;
    for (int l = 0; l < NLIST; l++) begin
      if (len_r[l] > npts) npts = len_r[l];
    end
    for (int l = 0; l < NLIST; l++) begin
      if (len_r[l] == '0 || (len_r[l] != LEN_W'(1) && len_r[l] != npts)) len_bad = 1'b1;
    end
  end

  // Point values: a single entry list repeats its one value
  logic [NUM_FUNC-1:0][LVL_W-1:0] pt_val;
  logic [LVL_W-1:0]               dwell_cur;
  logic [PTR_IDX_W-1:0]           last_idx;

  always_comb begin
    for (int f = 0; f < NUM_FUNC; f++) begin
      pt_val[f] = list_mem_r[f][(len_r[f] == LEN_W'(1)) ? '0 : idx_r];
    end
    dwell_cur = list_mem_r[DWL][(len_r[DWL] == LEN_W'(1)) ? '0 : idx_r];
    last_idx  = PTR_IDX_W'(npts - 1'b1);
  end

  // Pulse high time from width or from duty times period
  logic [22:0] duty_prod;
  logic [15:0] high_ticks;
  assign duty_prod  = pperiod_r * pulse_duty_percent_r;
  assign high_ticks = width_sel_r ? pwidth_r : 16'(duty_prod / 23'(PCT_FULL));

  ////////////////////////////////////////////////////////////////////////////
  // Shared prescaled tick for dwell and pulse timing
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      div_r  <= '0;
      tick_r <= 1'b0;
    end else if (div_r == TCK_W'(TICK_DIV - 1)) begin
      div_r  <= '0;
      tick_r <= 1'b1;
    end else begin
      div_r  <= div_r + 1'b1;
      tick_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trigger qualification and end of action target
  logic       trig_ok;
  ots_state_t done_st;
  logic [15:0] tnext;
  assign trig_ok = cfg_r.src_imm | cmd_trig;
  assign done_st = cfg_r.continuous ? ST_INIT : ST_IDLE;
  assign tnext   = tcnt_r + 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Trigger state machine and function outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      idx_r   <= '0;
      rep_r   <= '0;
      pdone_r <= '0;
      tcnt_r  <= '0;
      imm_r   <= '0;
      trg_r   <= '0;
      out_r   <= '0;
    end else begin
      for (int f = 0; f < NUM_FUNC; f++) begin
        if (wr_imm[f]) imm_r[f] <= reg_wdata[LVL_W-1:0];
        if (wr_trg[f]) trg_r[f] <= reg_wdata[LVL_W-1:0];
      end
      // Outside a transient non-list functions follow their immediate level
      if ((state_r == ST_IDLE || state_r == ST_INIT) && cfg_r.mode != MODE_LIST) out_r <= imm_r;
      if (cmd_abort) begin
        state_r <= ST_IDLE;
      end else begin
        case (state_r)
          ST_IDLE: begin
            // Triggers are not looked at here
            if (cmd_arm && !(cfg_r.mode == MODE_LIST && len_bad)) begin
              state_r <= ST_INIT;
              idx_r   <= '0;
              rep_r   <= 16'h0001;
            end
          end
          ST_INIT: begin
            if (trig_ok) state_r <= ST_DELAY;
          end
          ST_DELAY: begin
            if (!cfg_r.sync_phase || phase_ref == sync_ph_r) state_r <= ST_OUTPUT;
          end
          ST_OUTPUT: begin
            tcnt_r  <= '0;
            pdone_r <= '0;
            case (cfg_r.mode)
              MODE_STEP: begin
                out_r   <= trg_r;
                imm_r   <= trg_r;
                state_r <= done_st;
              end
              MODE_PULSE: begin
                out_r   <= trg_r;
                state_r <= ST_DWELL;
              end
              MODE_LIST: begin
                out_r   <= pt_val;
                state_r <= ST_DWELL;
              end
              default: state_r <= done_st;
            endcase
          end
          ST_DWELL: begin
            // Dwelling ignores triggers until the interval ends
            if (tick_r) begin
              tcnt_r <= tnext;
              if (cfg_r.mode == MODE_PULSE) begin
                if (tnext >= high_ticks) out_r <= imm_r;
                if (tnext >= pperiod_r) begin
                  tcnt_r  <= '0;
                  pdone_r <= pdone_r + 1'b1;
                  if (pdone_r + 1'b1 >= pcount_r) begin
                    out_r   <= imm_r;
                    state_r <= done_st;
                  end else begin
                    out_r <= trg_r;
                  end
                end
              end else if (tnext >= dwell_cur) begin
                if (idx_r == last_idx) begin
                  idx_r <= '0;
                  if (rep_r >= lcount_r) begin
                    state_r <= done_st;
                  end else begin
                    rep_r   <= rep_r + 1'b1;
                    state_r <= cfg_r.step_once ? ST_INIT : ST_OUTPUT;
                  end
                end else begin
                  idx_r   <= idx_r + 1'b1;
                  state_r <= cfg_r.step_once ? ST_INIT : ST_OUTPUT;
                end
              end
            end
          end
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Error, executed and save flags; a set wins over a clear
  logic list_done;
  assign list_done = (state_r == ST_DWELL) && (cfg_r.mode == MODE_LIST) && !cmd_abort && tick_r
                     && tnext >= dwell_cur && idx_r == last_idx && rep_r >= lcount_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      err_r   <= 1'b0;
      exec_r  <= 1'b0;
      saved_r <= 1'b0;
      sref_r  <= 1'b0;
      save_r  <= 1'b0;
    end else begin
      save_r <= cmd_save & exec_r;
      if (state_r == ST_IDLE && cmd_arm && !cmd_abort && cfg_r.mode == MODE_LIST && len_bad) err_r <= 1'b1;
      else if (cmd_clr) err_r <= 1'b0;
      if (list_done) exec_r <= 1'b1;
      else if (wr_ldat || wr_len != '0) exec_r <= 1'b0;
      if (cmd_save && exec_r) saved_r <= 1'b1;
      else if (cmd_clr) saved_r <= 1'b0;
      if (cmd_save && !exec_r) sref_r <= 1'b1;
      else if (cmd_clr) sref_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, valid in the cycle after the read strobe
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_r <= '0;
    end else if (reg_re) begin
      rdata_r <= '0;
      if (reg_addr == OFS_CFG) rdata_r[CFG_W-1:0] <= cfg_r;
      else if (reg_addr == OFS_SYNC_PH) rdata_r[PHASE_W-1:0] <= sync_ph_r;
      else if (reg_addr == OFS_PCOUNT) rdata_r[15:0] <= pcount_r;
      else if (reg_addr == OFS_PPERIOD) rdata_r[15:0] <= pperiod_r;
      else if (reg_addr == OFS_PDUTY) rdata_r[6:0] <= pulse_duty_percent_r;
      else if (reg_addr == OFS_PWIDTH) rdata_r[15:0] <= pwidth_r;
      else if (reg_addr == OFS_LCOUNT) rdata_r[15:0] <= lcount_r;
      else if (reg_addr == OFS_LPTR) rdata_r[PTR_SEL_W+PTR_IDX_W-1:0] <= lptr_r;
      else if (reg_addr == OFS_STATUS) begin
        rdata_r[ST_STATE_LSB+:3] <= state_r;
        rdata_r[ST_ERR_BIT]      <= err_r;
        rdata_r[ST_EXEC_BIT]     <= exec_r;
        rdata_r[ST_SAVED_BIT]    <= saved_r;
        rdata_r[ST_SREF_BIT]     <= sref_r;
      end
      for (int f = 0; f < NUM_FUNC; f++) begin
        if (reg_addr == OFS_IMM_BASE + ADDR_W'(WORD_BYTES * f)) rdata_r[LVL_W-1:0] <= imm_r[f];
        if (reg_addr == OFS_TRG_BASE + ADDR_W'(WORD_BYTES * f)) rdata_r[LVL_W-1:0] <= trg_r[f];
        if (reg_addr == OFS_OUT_BASE + ADDR_W'(WORD_BYTES * f)) rdata_r[LVL_W-1:0] <= out_r[f];
      end
      for (int l = 0; l < NLIST; l++) begin
        if (reg_addr == OFS_LEN_BASE + ADDR_W'(WORD_BYTES * l)) rdata_r[LEN_W-1:0] <= len_r[l];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs straight from flip-flops
  assign reg_rdata   = rdata_r;
  assign func_level  = out_r;
  assign seq_state   = state_r;
  assign save_strobe = save_r;

endmodule

/* File: shared/ots_pkg.sv */
// Shared constants, types and register map of the output transient sequencer
package ots_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Bus widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL     = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_CFG      = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_SYNC_PH  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PCOUNT   = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_PPERIOD  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_PDUTY    = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_PWIDTH   = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_LCOUNT   = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_LPTR     = 8'h24;
  localparam logic [ADDR_W-1:0] OFS_LDATA    = 8'h28;
  localparam logic [ADDR_W-1:0] OFS_IMM_BASE = 8'h40;  // One word per function
  localparam logic [ADDR_W-1:0] OFS_TRG_BASE = 8'h60;  // One word per function
  localparam logic [ADDR_W-1:0] OFS_LEN_BASE = 8'h80;  // Functions, then dwell list
  localparam logic [ADDR_W-1:0] OFS_OUT_BASE = 8'hA0;  // Present output levels
  localparam int              WORD_BYTES   = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Control register command bits (write only, self clearing)
  localparam int CTL_ARM   = 0;
  localparam int CTL_ABORT = 1;
  localparam int CTL_TRIG  = 2;
  localparam int CTL_SAVE  = 3;
  localparam int CTL_CLR   = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Status register fields
  localparam int ST_STATE_LSB = 0;
  localparam int ST_ERR_BIT   = 4;
  localparam int ST_EXEC_BIT  = 5;
  localparam int ST_SAVED_BIT = 6;
  localparam int ST_SREF_BIT  = 7;

  ////////////////////////////////////////////////////////////////////////////
  // List pointer fields: select in upper bits, point index below
  localparam int PTR_IDX_W   = 5;
  localparam int PTR_SEL_LSB = 5;
  localparam int PTR_SEL_W   = 2;

  ////////////////////////////////////////////////////////////////////////////
  // Transient modes and configuration word
  typedef enum logic [1:0] {
    MODE_FIXED = 2'h0,
    MODE_STEP  = 2'h1,
    MODE_PULSE = 2'h2,
    MODE_LIST  = 2'h3
  } ots_mode_t;

  typedef struct packed {
    logic      sync_phase;  // 1: start on phase angle
    logic      step_once;   // 1: trigger paced list
    logic      continuous;  // 1: re-arm after each action
    logic      src_imm;     // 1: immediate trigger source, 0: bus
    ots_mode_t mode;
  } ots_cfg_t;

  localparam int       CFG_W   = $bits(ots_cfg_t);
  localparam ots_cfg_t CFG_RST = '{sync_phase: 1'b0, step_once: 1'b0, continuous: 1'b0,
                                   src_imm: 1'b0, mode: MODE_FIXED};

  ////////////////////////////////////////////////////////////////////////////
  // Trigger state machine, Gray coded along idle-init-delay-output-dwell
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_INIT   = 3'h1,
    ST_DELAY  = 3'h3,
    ST_OUTPUT = 3'h2,
    ST_DWELL  = 3'h6
  } ots_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and scale constants
  localparam logic [15:0] LCOUNT_RST  = 16'h0001;
  localparam logic [15:0] PCOUNT_RST  = 16'h0001;
  localparam logic [15:0] PPERIOD_RST = 16'h0002;
  localparam logic [6:0]  PDUTY_RST   = 7'h32;
  localparam logic [15:0] PWIDTH_RST  = 16'h0001;
  localparam int          PCT_FULL    = 100;
  localparam int          PHASE_W     = 9;

  ////////////////////////////////////////////////////////////////////////////
  // Timing: one dwell and pulse tick per microsecond
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS       = 1000;
  localparam int TICK_CYC      = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

/* File: test/ots_chk.sv */
// Checker of the trigger state sequence
`timescale 1ns/1ps
module ots_chk
  import ots_pkg::*;
(
  // Clock, reset and writes
  input wire logic              clk,
  input wire logic              sys_rst,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic              reg_we,
  // Outputs
  input wire logic [2:0]        seq_state,
  input wire logic              save_strobe
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Control write decode
  wire logic ctl = reg_we && reg_addr == OFS_CTRL;
  ////////////////////////////////////////
  // State moves and save strobe source
  rst_idle_a: assert property ($fell(sys_rst) |-> seq_state == ST_IDLE) else $error("rst");
  idle_hold_a: assert property (seq_state == ST_IDLE && !(ctl && reg_wdata[CTL_ARM]) |=> seq_state == ST_IDLE)
    else $error("idle");
  abort_idle_a: assert property (ctl && reg_wdata[CTL_ABORT] |=> seq_state == ST_IDLE) else $error("abort");
  arm_init_a: assert property (seq_state == ST_IDLE && ctl |=> seq_state inside {ST_IDLE, ST_INIT})
    else $error("arm");
  init_next_a: assert property (seq_state == ST_INIT |=> seq_state inside {ST_INIT, ST_DELAY, ST_IDLE})
    else $error("init");
  delay_next_a: assert property (seq_state == ST_DELAY |=> seq_state inside {ST_DELAY, ST_OUTPUT, ST_IDLE})
    else $error("delay");
  out_next_a: assert property (seq_state == ST_OUTPUT |=> seq_state inside {ST_IDLE, ST_INIT, ST_DWELL})
    else $error("output");
  save_src_a: assert property (save_strobe |-> $past(ctl) && $past(reg_wdata[CTL_SAVE])) else $error("save");
  // Main scenarios
  cover property (seq_state == ST_DELAY ##1 seq_state == ST_OUTPUT);
  cover property (seq_state == ST_DWELL);
  cover property (save_strobe);
endmodule

/* File: test/ots_host.sv */
// Host controller model driving the register port
`timescale 1ns/1ps
module ots_host
  import ots_pkg::*;
(
  // Clock and read data
  input  wire logic              clk,
  input  wire logic [DATA_W-1:0] reg_rdata,
  // Requests
  output logic      [ADDR_W-1:0] reg_addr,
  output logic      [DATA_W-1:0] reg_wdata,
  output logic                   reg_we,
  output logic                   reg_re
);
  // Quiet bus at time zero
  initial {reg_addr, reg_wdata, reg_we, reg_re} = '0;
  ////////////////////////////////////////
  // One-cycle write strobe
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    {reg_we, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clk);
    reg_we <= 1'b0;
  endtask
  // One-cycle read strobe, data taken in the cycle after
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    {reg_re, reg_addr} <= {1'b1, a};
    @(posedge clk);
    reg_re <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask
endmodule

/* File: test/ots_sequencer_bench.sv */
// Self-checking bench of the output transient sequencer
`timescale 1ns/1ps
module ots_sequencer_bench;
  import ots_pkg::*;
  logic               clk = 1'b0;
  logic               sys_rst = 1'b1;
  logic [PHASE_W-1:0] phase_ref = '0;
  logic [ADDR_W-1:0]  reg_addr;
  logic [DATA_W-1:0]  reg_wdata, reg_rdata, rv;
  logic               reg_we, reg_re, save_strobe;
  logic [1:0][15:0]   func_level;
  logic [2:0]         seq_state;
  int                 mismatches = 0, n_checks = 0, n_out = 0, n_hi = 0;
  // Clock, host and design
  always #5 clk = ~clk;
  // Free running phase reference, one degree per clock
  always @(posedge clk) phase_ref <= (phase_ref == 9'h167) ? '0 : phase_ref + 1'b1;
  ots_host host (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re));
  ots_sequencer #(.TICK_DIV(1)) dut (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata), .phase_ref(phase_ref), .func_level(func_level),
    .seq_state(seq_state), .save_strobe(save_strobe));
  ////////////////////////////////////////
  // Compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Counts and verdict
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Bounded wait for a state, counting output cycles
  task automatic wait_st(input logic [2:0] s);
    #1;
    for (int i = 0; i < 500 && seq_state !== s; i++) begin
      @(posedge clk);
      #1;
      n_out += int'(seq_state === ST_OUTPUT);
      n_hi += int'(func_level[0] === 16'h0000);
    end
    chk("wait", seq_state, s);
    if (seq_state !== s)
      finish_test();
  endtask
  // Read compare, and write then state compare
  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [31:0] exp);
    host.rd(a, rv);
    chk("reg", rv, exp);
  endtask
  task automatic wst(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [2:0] s);
    host.wr(a, d);
    #1;
    chk("state", seq_state, s);
  endtask
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    rchk(OFS_LCOUNT, 32'h0000_0001);
    rchk(OFS_CFG, 32'h0000_0000);
    wst(OFS_CTRL, 32'h0000_0004, ST_IDLE);
    host.wr(OFS_TRG_BASE, 32'h0000_1234);
    host.wr(OFS_CFG, 32'h0000_0001);
    wst(OFS_CTRL, 32'h0000_0001, ST_INIT);
    wst(OFS_CTRL, 32'h0000_0004, ST_DELAY);
    @(posedge clk);
    #1;
    chk("state", seq_state, ST_OUTPUT);
    wait_st(ST_IDLE);
    chk("level", func_level[0], 32'h0000_1234);
    rchk(OFS_IMM_BASE, 32'h0000_1234);
    host.wr(OFS_CFG, 32'h0000_000D);
    host.wr(OFS_CTRL, 32'h0000_0001);
    wait_st(ST_DELAY);
    wait_st(ST_INIT);
    wst(OFS_CTRL, 32'h0000_0002, ST_IDLE);
    // Three point list, single entry second list and dwell, run twice
    host.wr(OFS_LEN_BASE, 32'h0000_0003);
    host.wr(OFS_LPTR, 32'h0000_0000);
    for (int i = 1; i < 4; i++) begin
      host.wr(OFS_LDATA, 32'(i) * 32'h0000_0011);
    end
    host.wr(OFS_LPTR, 32'h0000_0020);
    host.wr(OFS_LDATA, 32'h0000_0077);
    host.wr(OFS_LPTR, 32'h0000_0040);
    host.wr(OFS_LDATA, 32'h0000_0003);
    host.wr(OFS_LCOUNT, 32'h0000_0002);
    host.wr(OFS_CFG, 32'h0000_0003);
    host.wr(OFS_CTRL, 32'h0000_0008);
    #1;
    chk("save", save_strobe, 32'h0000_0000);
    rchk(OFS_STATUS, 32'h0000_0080);
    host.wr(OFS_CTRL, 32'h0000_0001);
    n_out = 0;
    host.wr(OFS_CTRL, 32'h0000_0004);
    wait_st(ST_IDLE);
    chk("points", n_out, 32'h0000_0006);
    chk("level", func_level, 32'h0077_0033);
    host.wr(OFS_CTRL, 32'h0000_0008);
    #1;
    chk("save", save_strobe, 32'h0000_0001);
    rchk(OFS_STATUS, 32'h0000_00E0);
    // Phase synchronised step at 90 degrees
    host.wr(OFS_SYNC_PH, 32'h0000_005A);
    host.wr(OFS_CFG, 32'h0000_0021);
    host.wr(OFS_CTRL, 32'h0000_0001);
    host.wr(OFS_CTRL, 32'h0000_0004);
    wait_st(ST_OUTPUT);
    chk("phase", phase_ref, 32'h0000_005B);
    // Two pulses of period 4 ticks, duty written after width
    host.wr(OFS_TRG_BASE, 32'h0000_0000);
    host.wr(OFS_PPERIOD, 32'h0000_0004);
    host.wr(OFS_PCOUNT, 32'h0000_0002);
    host.wr(OFS_PWIDTH, 32'h0000_0001);
    host.wr(OFS_PDUTY, 32'h0000_0032);
    host.wr(OFS_CFG, 32'h0000_0002);
    host.wr(OFS_CTRL, 32'h0000_0001);
    n_hi = 0;
    host.wr(OFS_CTRL, 32'h0000_0004);
    wait_st(ST_IDLE);
    chk("high", n_hi, 32'h0000_0004);
    chk("level", func_level[0], 32'h0000_1234);
    // Trigger paced list: one point per accepted trigger
    host.wr(OFS_CFG, 32'h0000_0013);
    host.wr(OFS_CTRL, 32'h0000_0001);
    host.wr(OFS_CTRL, 32'h0000_0004);
    wait_st(ST_INIT);
    chk("level", func_level[0], 32'h0000_0011);
    repeat (3) host.wr(OFS_CTRL, 32'h0000_0004);
    wait_st(ST_INIT);
    chk("level", func_level[0], 32'h0000_0022);
    wst(OFS_CTRL, 32'h0000_0002, ST_IDLE);
    host.wr(OFS_CTRL, 32'h0000_0010);
    host.wr(OFS_LEN_BASE + 8'h04, 32'h0000_0002);
    wst(OFS_CTRL, 32'h0000_0001, ST_IDLE);
    rchk(OFS_STATUS, 32'h0000_0010);
    finish_test();
  end
endmodule
bind ots_sequencer ots_chk chk_i (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_we(reg_we), .seq_state(seq_state), .save_strobe(save_strobe));
